// file: host_model.sv
module host_model (
    // Clock
    input  wire logic                  clk,
    // Register port toward the block
    output rx1_loss_pkg::reg_req_s     req,
    output rx1_loss_pkg::access_s      access,
    input  wire logic [7:0]            rd_data,
    input  wire logic                  rd_valid,
    input  wire logic                  access_denied
);
    timeunit 1ns;
    timeprecision 1ps;
    import rx1_loss_pkg::*;

    initial begin
        req    = '0;
        access = '0;
    end

    // Order of bits: level one, level two, rw grant, read grant, quick trip
    task automatic set_access(input logic [4:0] a);
        @(posedge clk);
        access <= access_s'(a);
    endtask

    // Released lines show the inverse so stale values never pass
    task automatic write_reg(input logic [7:0] addr, input logic [7:0] data, input logic page,
                             output logic denied);
        @(posedge clk);
        req <= '{wr_en: 1'b1, rd_en: 1'b0, addr: addr, wr_data: data, page_b: page};
        @(posedge clk);
        req <= '{wr_en: 1'b0, rd_en: 1'b0, addr: ~addr, wr_data: ~data, page_b: ~page};
        #1 denied = access_denied;
    endtask

    task automatic read_reg(input logic [7:0] addr, input logic page, output logic [7:0] data,
                            output logic valid, output logic denied);
        @(posedge clk);
        req <= '{wr_en: 1'b0, rd_en: 1'b1, addr: addr, wr_data: 8'h5a, page_b: page};
        @(posedge clk);
        req <= '{wr_en: 1'b0, rd_en: 1'b0, addr: ~addr, wr_data: 8'ha5, page_b: ~page};
        #1;
        data   = rd_data;
        valid  = rd_valid;
        denied = access_denied;
    endtask
endmodule

// file: rx1_loss_defines.svh
`ifndef RX1_LOSS_DEFINES_SVH
`define RX1_LOSS_DEFINES_SVH

// ==========================================================
// Register offsets
`define RANGE_SELECT_ADDR   8'hbc
`define RESERVED_GAP_ADDR   8'hbd
`define UPPER_TRIP_ADDR     8'hbe
`define LOWER_TRIP_ADDR     8'hbf

// ==========================================================
// Field positions of the range select register
`define UPPER_RANGE_MSB     6
`define UPPER_RANGE_LSB     4
`define LOWER_RANGE_MSB     2
`define LOWER_RANGE_LSB     0
`define RANGE_RSVD_HI_BIT   7
`define RANGE_RSVD_LO_BIT   3
`define RANGE_WRITE_MASK    8'h77

// ==========================================================
// Reset values
`define RANGE_SELECT_RESET  8'h00
`define UPPER_TRIP_RESET    8'h00
`define LOWER_TRIP_RESET    8'h00
`define RESERVED_GAP_VALUE  8'h00

// ==========================================================
// Full-scale fraction per range code, in hundredths of a percent
`define FRAC_CODE0          32'd10000
`define FRAC_CODE1          32'd8002
`define FRAC_CODE2          32'd6669
`define FRAC_CODE3          32'd5005
`define FRAC_CODE4          32'd4005
`define FRAC_CODE5          32'd3338
`define FRAC_CODE6          32'd2862
`define FRAC_CODE7          32'd2504
`define FRAC_FULL           32'd10000
`define TRIP_CODE_SHIFT     8

`endif

// file: rx1_loss_pkg.sv
package rx1_loss_pkg;

    typedef logic [2:0] range_code_t;

    typedef struct packed {
        logic       wr_en;
        logic       rd_en;
        logic [7:0] addr;
        logic [7:0] wr_data;
        logic       page_b;
    } reg_req_s;

    typedef struct packed {
        logic level_one_password;
        logic level_two_password;
        logic table_read_write_grant;
        logic table_read_grant;
        logic quick_trip_enable;
    } access_s;

    typedef struct packed {
        logic [7:0] range_select;
        logic [7:0] upper_trip;
        logic [7:0] lower_trip;
        logic       low_alarm;
        logic       high_alarm;
        logic [7:0] rd_data;
        logic       rd_valid;
        logic       access_denied;
    } state_s;

endpackage

// file: rx1_loss_threshold_regs.sv
`include "rx1_loss_defines.svh"

// Function
// - Range register scales upper and lower spans
// - Upper range field bits 6:4, default 0
// - Lower range field bits 2:0, default 0
// - Bits 7 and 3 reserved, zero
// - Reads need level two, or level one+grant
// - Range writes need level two or one+rw
// - Trip writes also need quick trip off
// - Upper trip is 8-bit binary code
// - Lower trip is 8-bit binary code
// - Below lower trip sets low alarm
// - Low alarm holds until above upper trip
// - Above upper clears low, sets high
// - Registers reset to 00h, retained storage
// - One storage shared by both address pages
// - Gap location reserved, reads 00h
// - Read-write grant defaults 0, widens access
// - Read grant defaults 0, read only
module rx1_loss_threshold_regs #(
    parameter int STRENGTH_W = 16
) (
    // Clock and reset
    input  wire logic                    clk,
    input  wire logic                    rst,
    // Register port from the serial interface
    input  wire rx1_loss_pkg::reg_req_s  req,
    output logic [7:0]                   rd_data,
    output logic                         rd_valid,
    output logic                         access_denied,
    // Password and grant state
    input  wire rx1_loss_pkg::access_s   access,
    // Fast path sample, full scale 1.25 V at all ones
    input  wire logic [STRENGTH_W-1:0]   rx1_signal_strength,
    input  wire logic                    sample_valid,
    // Configuration to the analog side and alarms
    output logic [7:0]                   range_select,
    output logic [7:0]                   upper_trip,
    output logic [7:0]                   lower_trip,
    output logic                         rx1_signal_lost_low_alarm,
    output logic                         rx1_signal_restored_high_alarm
);
    import rx1_loss_pkg::*;

    // ==========================================================
    // Functions
    function automatic logic [31:0] range_fraction(input range_code_t code);
        logic [31:0] f;
        f = `FRAC_CODE0;
        case (code)
            3'h0: f = `FRAC_CODE0;
            3'h1: f = `FRAC_CODE1;
            3'h2: f = `FRAC_CODE2;
            3'h3: f = `FRAC_CODE3;
            3'h4: f = `FRAC_CODE4;
            3'h5: f = `FRAC_CODE5;
            3'h6: f = `FRAC_CODE6;
            3'h7: f = `FRAC_CODE7;
            default: f = `FRAC_CODE0;
        endcase
        return f;
    endfunction

    // Result in units of the strength input; product stays below 2^30
    function automatic logic [STRENGTH_W-1:0] scaled_trip(input logic [7:0] code, input range_code_t rng);
        logic [31:0] prod;
        logic [31:0] quot;
        prod = (32'(code) * range_fraction(rng)) << (STRENGTH_W - `TRIP_CODE_SHIFT);
        quot = prod / `FRAC_FULL;
        return quot[STRENGTH_W-1:0];
    endfunction

    // ==========================================================
    // Access decode
    state_s                  st;
    state_s                  next_st;
    logic                    read_ok;
    logic                    write_ok;
    logic                    trip_write_ok;
    logic [STRENGTH_W-1:0]   upper_level;
    logic [STRENGTH_W-1:0]   lower_level;
    logic                    below_lower;
    logic                    above_upper;
    logic                    hit_range;
    logic                    hit_gap;
    logic                    hit_upper;
    logic                    hit_lower;

    assign read_ok = access.level_two_password
                   | (access.level_one_password & (access.table_read_write_grant
                                                  | access.table_read_grant));
    assign write_ok = access.level_two_password
                    | (access.level_one_password & access.table_read_write_grant);
    assign trip_write_ok = write_ok & ~access.quick_trip_enable;

    // Page select is ignored: both pages hit the same storage
    assign hit_range = (req.addr == `RANGE_SELECT_ADDR);
    assign hit_gap   = (req.addr == `RESERVED_GAP_ADDR);
    assign hit_upper = (req.addr == `UPPER_TRIP_ADDR);
    assign hit_lower = (req.addr == `LOWER_TRIP_ADDR);

    // ==========================================================
    // Comparator
    assign upper_level = scaled_trip(st.upper_trip,
                                     st.range_select[`UPPER_RANGE_MSB:`UPPER_RANGE_LSB]);
    assign lower_level = scaled_trip(st.lower_trip,
                                     st.range_select[`LOWER_RANGE_MSB:`LOWER_RANGE_LSB]);
    assign below_lower = rx1_signal_strength < lower_level;
    assign above_upper = rx1_signal_strength > upper_level;

    // ==========================================================
    // Next state
    always_comb begin
        next_st = st;
        next_st.rd_valid = 1'b0;
        next_st.access_denied = 1'b0;

        if (req.wr_en) begin
            if (hit_range && write_ok) begin
                next_st.range_select = req.wr_data & `RANGE_WRITE_MASK;
            end else if (hit_upper && trip_write_ok) begin
                next_st.upper_trip = req.wr_data;
            end else if (hit_lower && trip_write_ok) begin
                next_st.lower_trip = req.wr_data;
            end else if (hit_range || hit_upper || hit_lower) begin
                next_st.access_denied = 1'b1;
            end
        end

        if (req.rd_en) begin
            next_st.rd_valid = 1'b1;
            next_st.rd_data = 8'h00;
            if (!read_ok) begin
                next_st.access_denied = 1'b1;
            end else if (hit_range) begin
                next_st.rd_data = st.range_select;
            end else if (hit_upper) begin
                next_st.rd_data = st.upper_trip;
            end else if (hit_lower) begin
                next_st.rd_data = st.lower_trip;
            end else if (hit_gap) begin
                next_st.rd_data = `RESERVED_GAP_VALUE;
            end
        end

        // A crossed configuration lets the low side win, failing safe
        if (sample_valid) begin
            if (below_lower) begin
                next_st.low_alarm = 1'b1;
                next_st.high_alarm = 1'b0;
            end else if (above_upper) begin
                next_st.low_alarm = 1'b0;
                next_st.high_alarm = 1'b1;
            end
            // Between the levels both alarms hold
        end
    end

    // ==========================================================
    // State register; storage is retained outside, reset gives defaults
    always_ff @(posedge clk or posedge rst) begin
        if (rst) begin
            st.range_select <= `RANGE_SELECT_RESET;
            st.upper_trip <= `UPPER_TRIP_RESET;
            st.lower_trip <= `LOWER_TRIP_RESET;
            st.low_alarm <= 1'b0;
            st.high_alarm <= 1'b0;
            st.rd_data <= 8'h00;
            st.rd_valid <= 1'b0;
            st.access_denied <= 1'b0;
        end else begin
            st <= next_st;
        end
    end

    assign rd_data = st.rd_data;
    assign rd_valid = st.rd_valid;
    assign access_denied = st.access_denied;
    assign range_select = st.range_select;
    assign upper_trip = st.upper_trip;
    assign lower_trip = st.lower_trip;
    assign rx1_signal_lost_low_alarm = st.low_alarm;
    assign rx1_signal_restored_high_alarm = st.high_alarm;

    // ==========================================================
    // Assertions
    default clocking cb @(posedge clk); endclocking
    default disable iff (rst);

    a_range_write_gate: assert property (
        req.wr_en && hit_range && !write_ok |=> $stable(range_select))
        else $error("range select changed on a refused write");

    a_range_write_take: assert property (
        req.wr_en && hit_range && write_ok |=> range_select == ($past(req.wr_data) & 8'h77))
        else $error("range select did not take the written fields");

    a_range_rsvd_zero: assert property (
        range_select[7] == 1'b0 && range_select[3] == 1'b0)
        else $error("reserved range bits not zero");

    a_trip_qt_block: assert property (
        req.wr_en && (hit_upper || hit_lower) && access.quick_trip_enable
        |=> $stable(upper_trip) && $stable(lower_trip))
        else $error("trip level written while quick trip enabled");

    a_upper_write_take: assert property (
        req.wr_en && hit_upper && trip_write_ok |=> upper_trip == $past(req.wr_data))
        else $error("upper trip did not take written value");

    a_lower_write_take: assert property (
        req.wr_en && hit_lower && trip_write_ok |=> lower_trip == $past(req.wr_data))
        else $error("lower trip did not take written value");

    a_read_refused: assert property (
        req.rd_en && !read_ok |=> rd_valid && access_denied && rd_data == 8'h00)
        else $error("read not refused without access");

    a_gap_reads_zero: assert property (
        req.rd_en && hit_gap |=> rd_valid && rd_data == 8'h00)
        else $error("reserved gap read nonzero");

    a_low_alarm_set: assert property (
        sample_valid && below_lower |=> rx1_signal_lost_low_alarm && !rx1_signal_restored_high_alarm)
        else $error("low alarm not set below lower trip");

    a_low_alarm_hold: assert property (
        rx1_signal_lost_low_alarm && !(sample_valid && above_upper) |=> rx1_signal_lost_low_alarm)
        else $error("low alarm dropped without crossing upper trip");

    a_high_clears_low: assert property (
        sample_valid && above_upper && !below_lower
        |=> !rx1_signal_lost_low_alarm && rx1_signal_restored_high_alarm)
        else $error("upper crossing did not swap alarms");

    a_read_range_data: assert property (
        req.rd_en && read_ok && hit_range |=> rd_data == $past(range_select))
        else $error("range select read back wrong");

    a_read_upper_data: assert property (
        req.rd_en && read_ok && hit_upper |=> rd_data == $past(upper_trip))
        else $error("upper trip read back wrong");

    a_read_lower_data: assert property (
        req.rd_en && read_ok && hit_lower |=> rd_data == $past(lower_trip))
        else $error("lower trip read back wrong");

    a_range_denied: assert property (
        req.wr_en && hit_range && !write_ok |=> access_denied)
        else $error("refused range write not flagged");

    a_trip_denied: assert property (
        req.wr_en && (hit_upper || hit_lower) && !trip_write_ok |=> access_denied)
        else $error("refused trip write not flagged");

    a_upper_write_gate: assert property (
        req.wr_en && hit_upper && !trip_write_ok |=> $stable(upper_trip))
        else $error("upper trip changed on a refused write");

    a_lower_write_gate: assert property (
        req.wr_en && hit_lower && !trip_write_ok |=> $stable(lower_trip))
        else $error("lower trip changed on a refused write");

    a_high_alarm_hold: assert property (
        rx1_signal_restored_high_alarm && !(sample_valid && below_lower)
        |=> rx1_signal_restored_high_alarm)
        else $error("high alarm dropped without a low crossing");

    a_alarms_exclusive: assert property (
        !(rx1_signal_lost_low_alarm && rx1_signal_restored_high_alarm))
        else $error("low and high alarm set together");

    a_unmapped_silent: assert property (
        req.wr_en && !req.rd_en && !(hit_range || hit_upper || hit_lower) |=> !access_denied)
        else $error("write outside the registers flagged as refused");

    a_idle_alarms: assert property (
        !sample_valid |=> $stable(rx1_signal_lost_low_alarm) && $stable(rx1_signal_restored_high_alarm))
        else $error("alarm changed without a sample");

    a_rd_valid_pulse: assert property (
        req.rd_en |=> rd_valid)
        else $error("read not answered in one cycle");

    a_rd_valid_idle: assert property (
        !req.rd_en |=> !rd_valid)
        else $error("read valid without a read");

    a_rd_data_hold: assert property (
        !req.rd_en |=> $stable(rd_data))
        else $error("read data changed without a read");

    a_denied_idle: assert property (
        !req.wr_en && !req.rd_en |=> !access_denied)
        else $error("access denied without a request");

    // ==========================================================
    // Cover points
    c_range_write: cover property (req.wr_en && hit_range && write_ok ##1 range_select != 8'h00);
    c_low_alarm_set: cover property (sample_valid && below_lower ##1 rx1_signal_lost_low_alarm);
    c_refused_read: cover property (req.rd_en && !read_ok);
    c_hysteresis: cover property (
        rx1_signal_lost_low_alarm ##1 !rx1_signal_lost_low_alarm && rx1_signal_restored_high_alarm);
    c_qt_blocked: cover property (req.wr_en && hit_upper && write_ok && access.quick_trip_enable);

endmodule

// file: rx1_loss_threshold_regs_tb.sv
module rx1_loss_threshold_regs_tb;
    timeunit 1ns;
    timeprecision 1ps;
    import rx1_loss_pkg::*;

    logic            clk = 1'b0;
    logic            rst = 1'b1;
    reg_req_s        req;
    access_s         access;
    logic [7:0]      rd_data, range_select, upper_trip, lower_trip;
    logic            rd_valid, access_denied, lo_alarm, hi_alarm;
    logic [15:0]     strength = 16'h0000;
    logic            sample_valid = 1'b0;
    int              miscompares = 0;
    int              cmp_count = 0;
    int              frac[8] = '{10000, 8002, 6669, 5005, 4005, 3338, 2862, 2504};

    always #5 clk = ~clk;

    rx1_loss_threshold_regs #(.STRENGTH_W(16)) rx1_loss_threshold_regs_i (
        .clk(clk), .rst(rst), .req(req), .rd_data(rd_data), .rd_valid(rd_valid),
        .access_denied(access_denied), .access(access), .rx1_signal_strength(strength),
        .sample_valid(sample_valid), .range_select(range_select), .upper_trip(upper_trip),
        .lower_trip(lower_trip), .rx1_signal_lost_low_alarm(lo_alarm),
        .rx1_signal_restored_high_alarm(hi_alarm));

    host_model host_model_i (
        .clk(clk), .req(req), .access(access), .rd_data(rd_data), .rd_valid(rd_valid),
        .access_denied(access_denied));

    function automatic int level(int code, int trip);
        return trip * frac[code] * 256 / 10000;
    endfunction

    task automatic check(input logic [15:0] got, input logic [15:0] exp);
        cmp_count++;
        if (got !== exp) begin
            miscompares++;
            $display("wrong value at %0t: got %h expected %h", $time, got, exp);
        end
    endtask

    task automatic final_report();
        if (miscompares == 0 && cmp_count > 0) begin
            $display("Simulation passed");
        end else begin
            $display("Simulation failed");
        end
        $finish;
    endtask

    // Fast path sample, alarms read one cycle later
    task automatic sample(input int v, input logic lo, input logic hi);
        @(posedge clk);
        strength     <= v[15:0];
        sample_valid <= 1'b1;
        @(posedge clk);
        sample_valid <= 1'b0;
        strength     <= ~v[15:0];
        #1 check(16'({lo_alarm, hi_alarm}), 16'({lo, hi}));
    endtask

    initial begin
        #200us;
        miscompares++;
        final_report();
    end

    initial begin
        logic [7:0]  q, exp_range, exp_upper, exp_lower;
        logic        v, d, rd_ok, wr_ok;
        logic [4:0]  a;
        int          lo, up;
        repeat (20) @(posedge clk);
        rst <= 1'b0;
        // ==========================================================
        // Reset values, reserved gap, unmapped place
        host_model_i.set_access(5'b01000);
        host_model_i.write_reg(8'hbd, 8'hff, 1'b0, d);
        check(16'(d), 16'h0000);
        host_model_i.write_reg(8'h10, 8'hff, 1'b1, d);
        check(16'(d), 16'h0000);
        foreach (frac[k]) begin
            host_model_i.read_reg(k < 4 ? 8'hbc + 8'(k) : 8'h10 + 8'(k), k[0], q, v, d);
            check(16'({v, d, q}), 16'h0200);
        end
        // ==========================================================
        // Every password, grant and quick trip combination
        exp_range = 8'h00;
        exp_upper = 8'h00;
        exp_lower = 8'h00;
        for (int i = 0; i < 32; i++) begin
            a = i[4:0];
            host_model_i.set_access(a);
            rd_ok = a[3] | (a[4] & (a[2] | a[1]));
            wr_ok = a[3] | (a[4] & a[2]);
            host_model_i.write_reg(8'hbc, ~8'(i), i[1], d);
            if (wr_ok) exp_range = ~8'(i) & 8'h77;
            check(16'(d), 16'(!wr_ok));
            check(16'(range_select), 16'(exp_range));
            host_model_i.write_reg(8'hbe, 8'(i * 7), i[1], d);
            if (wr_ok && !a[0]) exp_upper = 8'(i * 7);
            check(16'(d), 16'(!(wr_ok && !a[0])));
            check(16'(upper_trip), 16'(exp_upper));
            host_model_i.write_reg(8'hbf, 8'(i * 5), ~i[1], d);
            if (wr_ok && !a[0]) exp_lower = 8'(i * 5);
            check(16'(d), 16'(!(wr_ok && !a[0])));
            check(16'(lower_trip), 16'(exp_lower));
            host_model_i.read_reg(8'hbe, ~i[1], q, v, d);
            check(16'({v, d, q}), {6'h00, 1'b1, !rd_ok, rd_ok ? exp_upper : 8'h00});
        end
        // ==========================================================
        // Hysteresis at every range code, both fields
        host_model_i.set_access(5'b01000);
        host_model_i.write_reg(8'hbf, 8'h80, 1'b1, d);
        check(16'(lower_trip), 16'h0080);
        host_model_i.write_reg(8'hbe, 8'hff, 1'b0, d);
        host_model_i.read_reg(8'hbf, 1'b0, q, v, d);
        check(16'(q), 16'h0080);
        for (int c = 0; c < 8; c++) begin
            host_model_i.write_reg(8'hbc, {1'b0, 3'(c), 1'b0, 3'(c)}, c[0], d);
            lo = level(c, 128);
            up = level(c, 255);
            sample(lo - 1, 1'b1, 1'b0);
            sample(lo, 1'b1, 1'b0);
            sample(up, 1'b1, 1'b0);
            sample(up + 1, 1'b0, 1'b1);
            sample(lo, 1'b0, 1'b1);
        end
        // ==========================================================
        // Reset in mid-run brings every register back to its default
        @(posedge clk);
        rst <= 1'b1;
        repeat (2) @(posedge clk);
        rst <= 1'b0;
        #1 check({upper_trip, lower_trip}, 16'h0000);
        check(16'({range_select, lo_alarm, hi_alarm}), 16'h0000);
        host_model_i.read_reg(8'hbc, 1'b1, q, v, d);
        check(16'({v, d, q}), 16'h0200);
        final_report();
    end
endmodule
